/* hw/ussu_pkg.sv */
// Constants and types for the universal serial shift unit
// Notes on behaviour
// - Shift clock at most half system clock
// - Start detector active only in two-wire mode
// - Start detection needs no software clocking
// - SDA fall with SCL high sets start flag
// - After start, hold SCL low until flag cleared
// - Two-wire slave samples SDA on SCL rise
// - Eight bits overflow counter, SCL forced low
// - SDA pulled low if MSB or port zero
// - Bytes flow one direction until stop/restart
// - No slew limiting, no input filtering
// - Writing one clears overflow; counter written
// - Sixteen toggle strobes complete one byte
// - Toggle/shift strobe pairs move one bit
// - External pin clock counts both edges
// - Counter preset to F overflows next edge
// - Software strobe increments counter too
// - Wire-mode field selects off, three, two-wire
// - Start hold in two-wire; pull-ups disabled
package ussu_pkg;
    // Wire modes in field order
    typedef enum logic [1:0] {
        WM_OFF,
        WM_THREE,
        WM_TWO,
        WM_TWO_HOLD
    } ussu_wire_mode_type;
    // Status word field positions
    localparam int ST_START_BIT = 7;
    localparam int ST_OVF_BIT = 6;
    localparam int ST_CNT_LSB = 0;
    // Control word field positions
    localparam int CT_SIE_BIT = 7;
    localparam int CT_OIE_BIT = 6;
    localparam int CT_WM_LSB = 4;
    localparam int CT_CS1_BIT = 3;
    localparam int CT_CS0_BIT = 2;
    localparam int CT_CLK_BIT = 1;
    localparam int CT_TC_BIT = 0;
    // Counter figures
    localparam logic [3:0] CNT_RESET = 4'h0;
    localparam logic [3:0] CNT_MAX = 4'hF;
    localparam logic [3:0] CNT_ACK_PRELOAD = 4'hE;
    // Reset values
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Pin levels before the first sample (bus idles high)
    localparam logic [1:0] PIN_RESET = 2'h3;
endpackage : ussu_pkg

/* hw/ussu_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module ussu_sync #(
    parameter int WIDTH = 2
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r; // First stage, read only by second

    // Plain two flops; no filter on purpose
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_r <= {WIDTH{1'b1}};
            o_sync <= {WIDTH{1'b1}};
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule // ussu_sync
`default_nettype wire

/* hw/ussu_top.sv */
// Universal serial shift unit: shifter, edge counter, two-wire clock control
`timescale 1ns/10ps
`default_nettype none
module ussu_top (
    input wire logic I_MCLK,
    input wire logic I_RST_B,
    input wire logic I_DATA_WR,
    input wire logic [7:0] I_DATA_WDATA,
    input wire logic I_STATUS_WR,
    input wire logic [7:0] I_STATUS_WDATA,
    input wire logic I_CONTROL_WR,
    input wire logic [7:0] I_CONTROL_WDATA,
    input wire logic I_TIMER_MATCH,
    input wire logic I_PORT_OUT_SDA,
    input wire logic I_PORT_OUT_SCL,
    input wire logic I_PORT_DIR_SDA,
    input wire logic I_PORT_DIR_SCL,
    input wire logic I_PORT_DIR_DO,
    input wire logic I_SDA_IN,
    input wire logic I_SCL_IN,
    output logic O_SDA_OUT,
    output logic O_SDA_OE,
    output logic O_SCL_OUT,
    output logic O_SCL_OE,
    output logic O_DO_OUT,
    output logic O_DO_OE,
    output logic O_SCL_TOGGLE,
    output logic O_PULLUP_OFF,
    output logic [7:0] O_SHIFT_DATA,
    output logic [7:0] O_STATUS,
    output logic [7:0] O_CONTROL,
    output logic O_START_IRQ,
    output logic O_OVF_IRQ
);
    import ussu_pkg::*;

    // Whole state of the block
    typedef struct packed {
        logic [7:0] shift;        // Shift data register
        logic [3:0] cnt;          // Edge counter
        logic start_flag;         // Start condition seen
        logic ovf_flag;           // Counter overflowed
        logic sie;                // Start interrupt enable
        logic oie;                // Overflow interrupt enable
        logic [1:0] wm;           // Wire mode field
        logic cs1;                // Clock source select
        logic cs0;                // Edge select
        logic clk_sel;            // Counter on toggle strobe
        logic sda_prev;           // Last synced SDA
        logic scl_prev;           // Last synced SCL
        logic start_hold;         // SCL held after start
        logic do_bit;             // Latched MSB for output
        logic sda_out;
        logic sda_oe;
        logic scl_out;
        logic scl_oe;
        logic do_out;
        logic do_oe;
        logic toggle;             // Port SCL toggle pulse
        logic pullup_off;
        logic start_irq;
        logic ovf_irq;
    } ussu_state_type;

    ussu_state_type st_r;
    ussu_state_type st_nxt;
    logic [1:0] pins_sync;       // {sda, scl} after two flops
    logic sda_s;
    logic scl_s;
    logic two_wire;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic shift_ev;
    logic count_ev;
    logic [3:0] cnt_inc;

    // Pins cross into the clock domain here
    ussu_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .i_clk(I_MCLK),
        .i_rst_b(I_RST_B),
        .i_async({I_SDA_IN, I_SCL_IN}),
        .o_sync(pins_sync)
    );

    assign sda_s = pins_sync[1];
    assign scl_s = pins_sync[0];

    // Next-state logic for the whole block
    always_comb begin
        logic cs1_e;
        logic cs0_e;
        logic clk_e;
        logic sw_strobe;
        logic tc_strobe;
        logic samp_edge;
        logic hold_ovf;
        logic drive_sda;
        cs1_e = st_r.cs1;
        cs0_e = st_r.cs0;
        clk_e = st_r.clk_sel;
        sw_strobe = 1'b0;
        tc_strobe = 1'b0;
        samp_edge = 1'b0;
        hold_ovf = 1'b0;
        drive_sda = 1'b0;
        st_nxt = st_r;
        // A control write acts with its own new settings
        if (I_CONTROL_WR) begin
            cs1_e = I_CONTROL_WDATA[CT_CS1_BIT];
            cs0_e = I_CONTROL_WDATA[CT_CS0_BIT];
            clk_e = I_CONTROL_WDATA[CT_CLK_BIT];
            sw_strobe = I_CONTROL_WDATA[CT_CLK_BIT];
            tc_strobe = I_CONTROL_WDATA[CT_TC_BIT];
            st_nxt.sie = I_CONTROL_WDATA[CT_SIE_BIT];
            st_nxt.oie = I_CONTROL_WDATA[CT_OIE_BIT];
            st_nxt.wm = I_CONTROL_WDATA[CT_WM_LSB+1:CT_WM_LSB];
            st_nxt.cs1 = cs1_e;
            st_nxt.cs0 = cs0_e;
            st_nxt.clk_sel = clk_e;
        end
        // Mode decode; upper code behaves as two-wire
        two_wire = st_nxt.wm[1];
        // Edges of the synced clock pin; a pin faster than
        // half the clock would lose edges here
        scl_rise = scl_s && !st_r.scl_prev;
        scl_fall = !scl_s && st_r.scl_prev;
        samp_edge = cs0_e ? scl_fall : scl_rise;
        // Clock source selection for the shifter
        if (cs1_e) begin
            shift_ev = samp_edge;
        end else if (cs0_e) begin
            shift_ev = I_TIMER_MATCH;
        end else begin
            shift_ev = sw_strobe;
        end
        // Counter source: pin counts both edges
        if (cs1_e && clk_e) begin
            count_ev = tc_strobe;
        end else if (cs1_e) begin
            count_ev = scl_rise || scl_fall;
        end else begin
            count_ev = shift_ev;
        end
        // Serial input always taken from the data pin
        if (I_DATA_WR) begin
            st_nxt.shift = I_DATA_WDATA;
        end else if (shift_ev) begin
            st_nxt.shift = {st_r.shift[6:0], sda_s};
        end
        // Output latch follows on the opposite pin edge; other clock sources and data writes latch the MSB at once
        if (I_DATA_WR || !cs1_e) begin
            st_nxt.do_bit = st_nxt.shift[7];
        end else if (cs0_e ? scl_rise : scl_fall) begin
            st_nxt.do_bit = st_r.shift[7];
        end
        // Counter: software load wins over a count
        cnt_inc = st_r.cnt + 4'h1;
        if (I_STATUS_WR) begin
            st_nxt.cnt = I_STATUS_WDATA[ST_CNT_LSB+3:ST_CNT_LSB];
        end else if (count_ev) begin
            st_nxt.cnt = cnt_inc;
        end
        // Overflow flag: clear by one; any status write blocks a new overflow
        if (I_STATUS_WR && I_STATUS_WDATA[ST_OVF_BIT]) begin
            st_nxt.ovf_flag = 1'b0;
        end
        if (count_ev && !I_STATUS_WR && st_r.cnt == CNT_MAX) begin
            st_nxt.ovf_flag = 1'b1;
        end
        // Start condition: SDA falls while SCL stays high;
        // purely pin-driven, no strobe or timer needed
        start_ev = two_wire && st_r.sda_prev && !sda_s && scl_s && st_r.scl_prev;
        if (I_STATUS_WR && I_STATUS_WDATA[ST_START_BIT]) begin
            st_nxt.start_flag = 1'b0;
        end
        if (start_ev) begin
            st_nxt.start_flag = 1'b1;
        end
        // Hold begins once the master pulls SCL low
        if (!st_nxt.start_flag || !two_wire) begin
            st_nxt.start_hold = 1'b0;
        end else if (!scl_s) begin
            st_nxt.start_hold = 1'b1;
        end
        // Overflow hold lasts until the flag is cleared
        hold_ovf = two_wire && st_nxt.ovf_flag;
        st_nxt.sda_prev = sda_s;
        st_nxt.scl_prev = scl_s;
        // Open-drain drivers only ever pull low
        st_nxt.sda_out = 1'b0;
        st_nxt.scl_out = 1'b0;
        drive_sda = !st_nxt.do_bit || !I_PORT_OUT_SDA;
        st_nxt.sda_oe = two_wire && I_PORT_DIR_SDA && drive_sda;
        st_nxt.scl_oe = two_wire && I_PORT_DIR_SCL
            && (!I_PORT_OUT_SCL || st_nxt.start_hold || hold_ovf);
        // Push-pull data out only in three-wire mode
        st_nxt.do_out = st_nxt.do_bit;
        st_nxt.do_oe = (st_nxt.wm == WM_THREE) && I_PORT_DIR_DO;
        st_nxt.toggle = tc_strobe;
        // Direct drive, no slew shaping; pull-ups off in two-wire mode
        st_nxt.pullup_off = two_wire;
        st_nxt.start_irq = st_nxt.start_flag && st_nxt.sie;
        st_nxt.ovf_irq = st_nxt.ovf_flag && st_nxt.oie;
    end

    // Single register stage for all state
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            st_r <= '0;
            st_r.shift <= DATA_RESET;
            st_r.cnt <= CNT_RESET;
            st_r.sda_prev <= PIN_RESET[1];
            st_r.scl_prev <= PIN_RESET[0];
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from state flops
    assign O_SDA_OUT = st_r.sda_out;
    assign O_SDA_OE = st_r.sda_oe;
    assign O_SCL_OUT = st_r.scl_out;
    assign O_SCL_OE = st_r.scl_oe;
    assign O_DO_OUT = st_r.do_out;
    assign O_DO_OE = st_r.do_oe;
    assign O_SCL_TOGGLE = st_r.toggle;
    assign O_PULLUP_OFF = st_r.pullup_off;
    assign O_SHIFT_DATA = st_r.shift;
    // Strobe bits always read as zero
    assign O_STATUS = {st_r.start_flag, st_r.ovf_flag, 2'h0, st_r.cnt};
    assign O_CONTROL = {st_r.sie, st_r.oie, st_r.wm, st_r.cs1, st_r.cs0, 2'h0};
    assign O_START_IRQ = st_r.start_irq;
    assign O_OVF_IRQ = st_r.ovf_irq;

    // Detector never fires outside two-wire mode
    property p_start_only_two;
        @(posedge I_MCLK) disable iff (!I_RST_B)
        $rose(st_r.start_flag) |-> st_r.wm[1];
    endproperty
    a_start_only_two: assert property (p_start_only_two)
        else $error("start flag set outside two-wire mode");

    // Start event sets flag next cycle
    property p_start_sets;
        @(posedge I_MCLK) disable iff (!I_RST_B)
        start_ev |=> st_r.start_flag;
    endproperty
    a_start_sets: assert property (p_start_sets)
        else $error("start condition did not set flag");

    // Start hold keeps SCL pulled while driver enabled
    property p_start_hold;
        @(posedge I_MCLK) disable iff (!I_RST_B)
        (st_nxt.start_hold && I_PORT_DIR_SCL) |=> O_SCL_OE;
    endproperty
    a_start_hold: assert property (p_start_hold)
        else $error("SCL not held after start");

    // Overflow in two-wire mode holds SCL until cleared
    property p_ovf_hold;
        @(posedge I_MCLK) disable iff (!I_RST_B)
        (two_wire && st_nxt.ovf_flag && I_PORT_DIR_SCL) |=> O_SCL_OE;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold)
        else $error("SCL not held on overflow");

    // SDA pulled low by zero MSB
    property p_sda_drive;
        @(posedge I_MCLK) disable iff (!I_RST_B)
        (two_wire && I_PORT_DIR_SDA && !st_nxt.do_bit) |=> (O_SDA_OE && !O_SDA_OUT);
    endproperty
    a_sda_drive: assert property (p_sda_drive)
        else $error("SDA not pulled low for zero bit");

    // Writing one clears overflow, even when a count is due
    property p_ovf_clear;
        @(posedge I_MCLK) disable iff (!I_RST_B)
        (I_STATUS_WR && I_STATUS_WDATA[ST_OVF_BIT]) |=> !st_r.ovf_flag;
    endproperty
    a_ovf_clear: assert property (p_ovf_clear)
        else $error("overflow flag not cleared by write");

    // Preset F overflows on the next counted edge
    property p_wrap;
        @(posedge I_MCLK) disable iff (!I_RST_B)
        (count_ev && !I_STATUS_WR && st_r.cnt == 4'hF)
            |=> (st_r.ovf_flag && st_r.cnt == 4'h0);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("counter did not overflow from F");

    // Pin edges both count in external mode
    property p_both_edges;
        @(posedge I_MCLK) disable iff (!I_RST_B)
        (st_r.cs1 && !st_r.clk_sel && !I_CONTROL_WR && !I_STATUS_WR
            && (scl_rise || scl_fall)) |=> (st_r.cnt == $past(st_r.cnt) + 4'h1);
    endproperty
    a_both_edges: assert property (p_both_edges)
        else $error("pin edge not counted");

    // Software strobe shifts one bit, MSB first
    property p_sw_shift;
        @(posedge I_MCLK) disable iff (!I_RST_B)
        (shift_ev && !I_DATA_WR) |=> (st_r.shift[7:1] == $past(st_r.shift[6:0]));
    endproperty
    a_sw_shift: assert property (p_sw_shift)
        else $error("shift did not move one bit");

    // Mode off releases every driver
    property p_off_quiet;
        @(posedge I_MCLK) disable iff (!I_RST_B)
        (st_nxt.wm == WM_OFF) |=> (!O_SDA_OE && !O_SCL_OE && !O_DO_OE);
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("driver active with outputs disabled");

    // Software strobe advances the counter by one
    property p_sw_count;
        @(posedge I_MCLK) disable iff (!I_RST_B)
        (I_CONTROL_WR && !I_CONTROL_WDATA[CT_CS1_BIT] && !I_CONTROL_WDATA[CT_CS0_BIT]
            && I_CONTROL_WDATA[CT_CLK_BIT] && !I_STATUS_WR)
            |=> (st_r.cnt == $past(st_r.cnt) + 4'h1);
    endproperty
    a_sw_count: assert property (p_sw_count)
        else $error("software strobe did not count");

    // Clearing the start flag ends the start hold
    property p_start_release;
        @(posedge I_MCLK) disable iff (!I_RST_B)
        (I_STATUS_WR && I_STATUS_WDATA[ST_START_BIT] && !start_ev)
            |=> (!st_r.start_flag && !st_r.start_hold);
    endproperty
    a_start_release: assert property (p_start_release)
        else $error("start hold not released by flag clear");

    // Two-wire selection turns the pull-ups off
    property p_pullup_off;
        @(posedge I_MCLK) disable iff (!I_RST_B)
        (I_CONTROL_WR && I_CONTROL_WDATA[CT_WM_LSB+1]) |=> O_PULLUP_OFF;
    endproperty
    a_pullup_off: assert property (p_pullup_off)
        else $error("pull-ups left on in two-wire mode");

    // Overflow with its enable raises the request
    property p_ovf_irq;
        @(posedge I_MCLK) disable iff (!I_RST_B)
        (count_ev && !I_STATUS_WR && st_r.cnt == CNT_MAX && st_nxt.oie)
            |=> O_OVF_IRQ;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq)
        else $error("overflow request missing");
endmodule // ussu_top
`default_nettype wire

/* sim/universal_serial_shift_unit_tb.sv */
// Self-checking bench for the serial shift unit
`timescale 1ns/10ps
`default_nettype none
module universal_serial_shift_unit_tb;
    import ussu_pkg::*;
    logic clk = 1'b0; // System clock
    logic rst_b = 1'b0; // Reset, active low
    logic dwr = 1'b0, swr = 1'b0, cwr = 1'b0, tmr = 1'b0; // Strobes
    logic [7:0] dwd = 8'h00, swd = 8'h00, cwd = 8'h00; // Write data
    logic po_sda = 1'b1, po_scl = 1'b1, pd = 1'b1; // Port bits
    logic m_scl_low, m_sda_low; // Master pulls
    logic sda_o, sda_oe, scl_o, scl_oe, do_o, do_oe, tgl, pu_off, s_irq, o_irq;
    logic [7:0] sd, st, ct; // Register views
    wire logic scl_w; // Bus lines with pull-ups
    wire logic sda_w;
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [7:0] rnd = 8'h1D; // Random state
    logic [7:0] d;

    assign scl_w = ~(m_scl_low | (scl_oe & ~scl_o));
    assign sda_w = ~(m_sda_low | (sda_oe & ~sda_o));

    ussu_top u_ussu_top (
        .I_MCLK(clk), .I_RST_B(rst_b), .I_DATA_WR(dwr), .I_DATA_WDATA(dwd),
        .I_STATUS_WR(swr), .I_STATUS_WDATA(swd), .I_CONTROL_WR(cwr),
        .I_CONTROL_WDATA(cwd), .I_TIMER_MATCH(tmr), .I_PORT_OUT_SDA(po_sda),
        .I_PORT_OUT_SCL(po_scl), .I_PORT_DIR_SDA(pd), .I_PORT_DIR_SCL(pd),
        .I_PORT_DIR_DO(pd), .I_SDA_IN(sda_w), .I_SCL_IN(scl_w), .O_SDA_OUT(sda_o),
        .O_SDA_OE(sda_oe), .O_SCL_OUT(scl_o), .O_SCL_OE(scl_oe), .O_DO_OUT(do_o),
        .O_DO_OE(do_oe), .O_SCL_TOGGLE(tgl), .O_PULLUP_OFF(pu_off),
        .O_SHIFT_DATA(sd), .O_STATUS(st), .O_CONTROL(ct), .O_START_IRQ(s_irq),
        .O_OVF_IRQ(o_irq)
    );

    ussu_partner u_ussu_partner (
        .i_scl(scl_w), .i_sda(sda_w), .o_scl_low(m_scl_low), .o_sda_low(m_sda_low)
    );

    // 200 MHz clock
    always #2.5 clk = ~clk;

    // Hang guard, far above the expected run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            summarize();
        end
    end

    // Next pseudo-random byte
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Expected status word from flags and count
    function automatic logic [7:0] exp_st(input logic s, input logic o, input logic [3:0] n);
        return {s, o, 2'h0, n};
    endfunction

    // Compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // Wait n edges, then let outputs settle
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Register write: 0 data, 1 status, 2 control
    task automatic wr(input int k, input logic [7:0] v);
        @(posedge clk);
        #1;
        if (k == 0) begin
            dwr = 1'b1;
            dwd = v;
        end else if (k == 1) begin
            swr = 1'b1;
            swd = v;
        end else begin
            cwr = 1'b1;
            cwd = v;
        end
        @(posedge clk);
        #1;
        dwr = 1'b0;
        swr = 1'b0;
        cwr = 1'b0;
    endtask

    // Verdict and end of run
    task automatic summarize();
        if (fails == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        wt(12);
        rst_b = 1'b1;
        chk(st, 8'h00);
        chk(ct, 8'h00);
        chk(sd, 8'h00);
        // Software strobe pairs, random data
        for (int i = 0; i < 2; i++) begin
            rnd = lfsr_next(rnd);
            d = rnd;
            wr(0, d);
            wr(1, 8'h40);
            for (int j = 0; j < 8; j++) begin
                wr(2, 8'h11);
                wr(2, 8'h13);
                if (j == 3) begin
                    chk(sd, {d[3:0], 4'hF});
                    chk(do_o, d[3]);
                    chk(do_oe, 8'h01);
                    chk(pu_off, 8'h00);
                end
            end
            chk(st, 8'h08);
            chk(ct, 8'h10);
        end
        // Sixteen toggle strobes give one overflow
        wr(1, 8'h40);
        for (int i = 0; i < 16; i++) begin
            wr(2, 8'h5B);
            chk(tgl, 8'h01);
        end
        chk(st, 8'h40);
        chk(o_irq, 8'h01);
        wr(1, 8'h43);
        chk(st, 8'h03);
        chk(o_irq, 8'h00);
        // Preset to F, one timer match overflows
        wr(2, 8'h14);
        wr(1, 8'h4F);
        @(posedge clk);
        #1 tmr = 1'b1;
        wt(1);
        tmr = 1'b0;
        wt(2);
        chk(st, 8'h40);
        // Pin clock counts both edges; falling edge samples here
        wr(2, 8'h1C);
        wr(0, 8'h80);
        wr(1, 8'h4F);
        u_ussu_partner.set_scl(1'b1);
        wt(10);
        chk(st, exp_st(1'b0, 1'b1, 4'h0));
        chk(sd, 8'h01);
        chk(do_o, 8'h01);
        u_ussu_partner.set_scl(1'b0);
        wt(10);
        chk(st, exp_st(1'b0, 1'b1, 4'h1));
        chk(sd, 8'h01);
        chk(do_o, 8'h00);
        // No start detection outside two-wire mode
        for (int i = 0; i < 2; i++) begin
            wr(2, (i == 0) ? 8'h08 : 8'h18);
            wr(1, 8'hF0);
            u_ussu_partner.start_cond();
            u_ussu_partner.stop_cond();
            chk(st[7], 8'h00);
        end
        // Two-wire slave: start, hold, byte, acknowledge
        wr(0, 8'hFF);
        wr(2, 8'hA8);
        wr(1, 8'hF0);
        chk(pu_off, 8'h01);
        u_ussu_partner.start_cond();
        chk(st[7], 8'h01);
        chk(s_irq, 8'h01);
        chk(scl_oe, 8'h01);
        wr(1, 8'hF0);
        wt(3);
        chk(scl_oe, 8'h00);
        rnd = lfsr_next(rnd);
        d = rnd | 8'h80;
        u_ussu_partner.send_byte(d);
        wt(8);
        chk(sd, d);
        chk(st, 8'h40);
        chk(scl_oe, 8'h01);
        chk(scl_o, 8'h00);
        wr(0, 8'h00);
        chk(sda_oe, 8'h01);
        chk(sda_o, 8'h00);
        wr(1, {4'h4, CNT_ACK_PRELOAD});
        u_ussu_partner.send_bit(1'b1);
        wt(8);
        chk(st, 8'h40);
        chk(scl_oe, 8'h01);
        chk(sd[0], 8'h00);
        wr(0, 8'hFF);
        wr(1, 8'h40);
        wt(3);
        chk(scl_oe, 8'h00);
        chk(sda_oe, 8'h00);
        po_sda = 1'b0;
        wt(3);
        chk(sda_oe, 8'h01);
        po_sda = 1'b1;
        u_ussu_partner.stop_cond();
        // Idle slave waits for the next start, which holds SCL again
        u_ussu_partner.start_cond();
        chk(st[7], 8'h01);
        chk(scl_oe, 8'h01);
        summarize();
    end
endmodule // universal_serial_shift_unit_tb
`default_nettype wire

/* sim/ussu_partner.sv */
// Far-side two-wire master model with open-drain pulls
`timescale 1ns/10ps
`default_nettype none
module ussu_partner (
    input wire logic i_scl,
    input wire logic i_sda,
    output var logic o_scl_low,
    output var logic o_sda_low
);
    // Half of the 48 ns link period, well under the system clock limit
    localparam int HALF_NS = 24;

    // Both lines released at time zero
    initial begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
    end

    // SDA falls while SCL stays high, then SCL is pulled low
    task automatic start_cond();
        o_sda_low = 1'b1;
        #(10 * HALF_NS);
        o_scl_low = 1'b1;
        #(10 * HALF_NS);
    endtask

    // Stop: SCL released first, then SDA rises
    task automatic stop_cond();
        o_scl_low = 1'b0;
        #(4 * HALF_NS);
        o_sda_low = 1'b0;
        #(4 * HALF_NS);
    endtask

    // Direct pull on SCL, used as a plain edge source
    task automatic set_scl(input logic pull);
        o_scl_low = pull;
    endtask

    // One clock pulse; SCL may be stretched by the slave
    task automatic send_bit(input logic b);
        int n;
        n = 0;
        o_sda_low = ~b;
        #(HALF_NS);
        o_scl_low = 1'b0;
        // Bounded wait until the line really went high
        while (i_scl !== 1'b1 && n < 4000) begin
            #1;
            n++;
        end
        #(HALF_NS);
        o_scl_low = 1'b1;
        #(HALF_NS);
    endtask

    // Whole byte, most significant bit first
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            send_bit(b[i]);
        end
    endtask
endmodule // ussu_partner
`default_nettype wire
